/* File: tfa_pkg.sv */
// Package for the timer flag, periodic interrupt and pulse accumulator block.
// Assumes an APB slave with 32-bit data; registers are byte wide in the low bits.
package tfa_pkg;
   localparam logic [11:0] ADDR_EDGE_CTRL = 12'h000;
   localparam logic [11:0] ADDR_MASK_ONE = 12'h004;
   localparam logic [11:0] ADDR_FLAGS_ONE = 12'h008;
   localparam logic [11:0] ADDR_MASK_TWO = 12'h00c;
   localparam logic [11:0] ADDR_FLAGS_TWO = 12'h010;
   localparam logic [11:0] ADDR_ACC_CTRL = 12'h014;
   localparam logic [11:0] ADDR_ACC_COUNT = 12'h018;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [5:0] EDGE_CTRL_MASK = 6'h3f;
   // Second flag and mask register bit positions.
   localparam int BIT_OVF = 7;
   localparam int BIT_PERIODIC = 6;
   localparam int BIT_ACC_OVF = 5;
   localparam int BIT_ACC_EDGE = 4;
   // Accumulator control bit positions.
   localparam int BIT_DIR = 7;
   localparam int BIT_ENABLE = 6;
   localparam int BIT_MODE = 5;
   localparam int BIT_EDGE_POL = 4;
   localparam int BIT_RATE_HI = 1;
   localparam int BIT_RATE_LO = 0;
   localparam logic [7:0] FLAGS_TWO_IMPL = 8'hf0;
   localparam int GATED_DIV = 64;
   localparam int RTI_BASE = 8192;
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_ANY = 2'h3;
   typedef struct packed {
      logic [4:0] compare_event;
      logic [2:0] capture_pin;
   } tfa_events_t;
   typedef struct packed {
      logic [7:0] timer_one;
      logic periodic;
      logic acc_edge;
      logic acc_overflow;
   } tfa_irq_t;
endpackage : tfa_pkg

/* File: tfa_top.sv */
// Timer flags, capture edge selection, periodic interrupt and pulse accumulator.
// Assumes synchronous inputs on pclk and an APB master that waits for pready.
// Contract
// - Two-bit edge selector per capture: off, rising, falling, both.
// - Reset clears all capture edge selectors.
// - Edge control bits 7 and 6 read zero.
// - Compare flag and its mask together raise that compare request.
// - Capture flag and its mask together raise that capture request.
// - Flags set regardless of mask; mask only gates requests.
// - Timer flags clear only by writing one; zero leaves them.
// - Accumulator edge flag sets on active pin edge while the enable bit is set; clear with bit 4.
// - Second flag register bits 3 to 0 read zero.
// - Two-bit rate field selects one of four periodic rates.
// - Each period sets periodic flag; request only when enabled.
// - First periodic flag needs one whole period after reset.
// - Eight-bit readable writable accumulator; mode picks events or gated time.
// - Gated mode counts clock divided by 64 while pin enables.
// - Shared pin level feeds the accumulator even when output.
// - Direction bit makes the shared pin input at zero, output at one.
// - Enable bit turns the accumulator off or on.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns
module tfa_top #(
   parameter int RTI_BASE_CYCLES = tfa_pkg::RTI_BASE
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire tfa_pkg::tfa_events_t events_in,
   input wire logic timer_overflow,
   input wire logic shared_pin_in,
   input wire logic shared_pin_out_value,
   output logic shared_pin_out,
   output logic shared_pin_oe_n,
   output tfa_pkg::tfa_irq_t irq,
   output logic [2:0] capture_strobe
);
   import tfa_pkg::*;

   initial begin
      if (RTI_BASE_CYCLES < 2) begin
         $error("RTI_BASE_CYCLES must be at least 2");
      end
   end

   logic [5:0] capture_edge_control_reg;
   logic [7:0] timer_interrupt_mask_one_reg;
   logic [7:0] timer_interrupt_flags_one_reg;
   logic [7:0] timer_interrupt_mask_two_reg;
   logic [7:0] timer_interrupt_flags_two_reg;
   logic [7:0] accumulator_control_reg;
   logic [7:0] acc_count_reg;
   logic [2:0] capture_prev_reg;
   logic pin_prev_reg;
   logic [5:0] gate_div_reg;
   logic [31:0] rti_count_reg;
   logic [31:0] rti_period;
   logic rti_tick;
   logic wr_en;
   logic rd_en;
   logic byte_wr;
   logic [7:0] wbyte;
   logic [7:0] flags_one_set;
   logic [7:0] flags_two_set;
   logic pin_rise;
   logic pin_fall;
   logic pin_edge;
   logic pin_active_level;
   logic acc_inc;
   logic acc_wrap;
   logic [7:0] rdata_next;
   logic addr_ok;

   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   assign byte_wr = wr_en & pstrb[0];
   assign wbyte = pwdata[7:0];

   always_comb begin
      case (paddr)
         ADDR_EDGE_CTRL, ADDR_MASK_ONE, ADDR_FLAGS_ONE, ADDR_MASK_TWO,
         ADDR_FLAGS_TWO, ADDR_ACC_CTRL, ADDR_ACC_COUNT: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~addr_ok;

   // Capture edge detection per channel.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cap
         logic [1:0] sel;
         logic rise;
         logic fall;
         assign sel = capture_edge_control_reg[2*gi +: 2];
         assign rise = events_in.capture_pin[gi] & ~capture_prev_reg[gi];
         assign fall = ~events_in.capture_pin[gi] & capture_prev_reg[gi];
         always_comb begin
            case (sel)
               EDGE_RISE: capture_strobe[gi] = rise;
               EDGE_FALL: capture_strobe[gi] = fall;
               EDGE_ANY: capture_strobe[gi] = rise | fall;
               default: capture_strobe[gi] = 1'b0;
            endcase
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_prev_reg <= 3'h0;
         pin_prev_reg <= 1'b0;
      end else begin
         capture_prev_reg <= events_in.capture_pin;
         pin_prev_reg <= shared_pin_out;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_edge_control_reg <= 6'h00;
      end else if (byte_wr && paddr == ADDR_EDGE_CTRL) begin
         capture_edge_control_reg <= wbyte[5:0] & EDGE_CTRL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_interrupt_mask_one_reg <= RESET_BYTE;
         timer_interrupt_mask_two_reg <= RESET_BYTE;
         accumulator_control_reg <= RESET_BYTE;
      end else if (byte_wr) begin
         if (paddr == ADDR_MASK_ONE) begin
            timer_interrupt_mask_one_reg <= wbyte;
         end
         if (paddr == ADDR_MASK_TWO) begin
            timer_interrupt_mask_two_reg <= wbyte & FLAGS_TWO_IMPL;
         end
         if (paddr == ADDR_ACC_CTRL) begin
            accumulator_control_reg <= wbyte;
         end
      end
   end

   // Shared pin: the level seen by the accumulator is the pin itself.
   assign shared_pin_oe_n = ~accumulator_control_reg[BIT_DIR];
   assign shared_pin_out = accumulator_control_reg[BIT_DIR] ? shared_pin_out_value : shared_pin_in;
   assign pin_rise = shared_pin_out & ~pin_prev_reg;
   assign pin_fall = ~shared_pin_out & pin_prev_reg;
   assign pin_edge = accumulator_control_reg[BIT_EDGE_POL] ? pin_rise : pin_fall;
   assign pin_active_level = accumulator_control_reg[BIT_EDGE_POL] ? shared_pin_out : ~shared_pin_out;

   // Free-running divide by 64 for gated time mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_div_reg <= 6'h00;
      end else begin
         gate_div_reg <= gate_div_reg + 6'h01;
      end
   end

   always_comb begin
      if (!accumulator_control_reg[BIT_ENABLE]) begin
         acc_inc = 1'b0;
      end else if (accumulator_control_reg[BIT_MODE]) begin
         acc_inc = pin_active_level && gate_div_reg == 6'(GATED_DIV - 1);
      end else begin
         acc_inc = pin_edge;
      end
   end
   assign acc_wrap = acc_inc && acc_count_reg == 8'hff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_count_reg <= RESET_BYTE;
      end else if (byte_wr && paddr == ADDR_ACC_COUNT) begin
         acc_count_reg <= wbyte;
      end else if (acc_inc) begin
         acc_count_reg <= acc_count_reg + 8'h01;
      end
   end

   // Periodic interrupt period is the base times 1, 2, 4 or 8.
   assign rti_period = 32'(RTI_BASE_CYCLES) << accumulator_control_reg[BIT_RATE_HI:BIT_RATE_LO];
   assign rti_tick = rti_count_reg >= rti_period - 32'h1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rti_count_reg <= 32'h0;
      end else if (rti_tick) begin
         rti_count_reg <= 32'h0;
      end else begin
         rti_count_reg <= rti_count_reg + 32'h1;
      end
   end

   assign flags_one_set = {events_in.compare_event, capture_strobe};
   always_comb begin
      flags_two_set = 8'h00;
      flags_two_set[BIT_OVF] = timer_overflow;
      flags_two_set[BIT_PERIODIC] = rti_tick;
      flags_two_set[BIT_ACC_OVF] = acc_wrap;
      flags_two_set[BIT_ACC_EDGE] = accumulator_control_reg[BIT_ENABLE] & pin_edge;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_interrupt_flags_one_reg <= RESET_BYTE;
      end else begin
         if (byte_wr && paddr == ADDR_FLAGS_ONE) begin
            timer_interrupt_flags_one_reg <= (timer_interrupt_flags_one_reg & ~wbyte) | flags_one_set;
         end else begin
            timer_interrupt_flags_one_reg <= timer_interrupt_flags_one_reg | flags_one_set;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_interrupt_flags_two_reg <= RESET_BYTE;
      end else begin
         if (byte_wr && paddr == ADDR_FLAGS_TWO) begin
            timer_interrupt_flags_two_reg <= ((timer_interrupt_flags_two_reg & ~wbyte) | flags_two_set)
               & FLAGS_TWO_IMPL;
         end else begin
            timer_interrupt_flags_two_reg <= (timer_interrupt_flags_two_reg | flags_two_set) & FLAGS_TWO_IMPL;
         end
      end
   end

   always_comb begin
      irq.timer_one = timer_interrupt_flags_one_reg & timer_interrupt_mask_one_reg;
      irq.periodic = timer_interrupt_flags_two_reg[BIT_PERIODIC] & timer_interrupt_mask_two_reg[BIT_PERIODIC];
      irq.acc_edge = timer_interrupt_flags_two_reg[BIT_ACC_EDGE] & timer_interrupt_mask_two_reg[BIT_ACC_EDGE];
      irq.acc_overflow = timer_interrupt_flags_two_reg[BIT_ACC_OVF] & timer_interrupt_mask_two_reg[BIT_ACC_OVF];
   end

   always_comb begin
      case (paddr)
         ADDR_EDGE_CTRL: rdata_next = {2'h0, capture_edge_control_reg};
         ADDR_MASK_ONE: rdata_next = timer_interrupt_mask_one_reg;
         ADDR_FLAGS_ONE: rdata_next = timer_interrupt_flags_one_reg;
         ADDR_MASK_TWO: rdata_next = timer_interrupt_mask_two_reg;
         ADDR_FLAGS_TWO: rdata_next = timer_interrupt_flags_two_reg & FLAGS_TWO_IMPL;
         ADDR_ACC_CTRL: rdata_next = accumulator_control_reg;
         ADDR_ACC_COUNT: rdata_next = acc_count_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // Read data is captured in the setup cycle and stands through the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_en) begin
         prdata <= {24'h0, rdata_next};
      end
   end
endmodule : tfa_top

/* File: tfa_sva.sv */
// Checker for the timer flag block, watching only the top module ports.
// Assumes zero-wait APB writes that act at the access edge.
`timescale 1ns/1ns
module tfa_sva
   import tfa_pkg::*;
#(
   parameter int RTI_BASE_CYCLES = tfa_pkg::RTI_BASE
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire tfa_pkg::tfa_irq_t irq,
   input wire logic [2:0] capture_strobe,
   input wire logic shared_pin_in,
   input wire logic shared_pin_out_value,
   input wire logic shared_pin_out,
   input wire logic shared_pin_oe_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   logic rd;
   logic [15:0] cnt;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   // Cycles since reset release, saturating.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt <= '0;
      else if (cnt != 16'hffff) cnt <= cnt + 16'h1;
   end
   AST_PIN_IN: assert property (shared_pin_oe_n |-> shared_pin_out == shared_pin_in)
      else $error("pin level not taken from input");
   AST_PIN_OUT: assert property (!shared_pin_oe_n |-> shared_pin_out == shared_pin_out_value)
      else $error("driven pin level wrong");
   AST_RST: assert property ($rose(presetn) |-> capture_strobe == 3'h0 && irq == '0)
      else $error("activity right after reset");
   AST_EDGE_HI: assert property (rd && paddr == ADDR_EDGE_CTRL |-> prdata[7:6] == 2'h0)
      else $error("edge control upper bits not zero");
   AST_FLAGS_LO: assert property (rd && paddr == ADDR_FLAGS_TWO |-> prdata[3:0] == 4'h0)
      else $error("second flags low bits not zero");
   AST_NO_DROP: assert property (!wr |=> (irq & $past(irq)) == $past(irq))
      else $error("request dropped without a write");
   AST_MASK_ONE: assert property (wr && paddr == ADDR_MASK_ONE && pwdata[7:0] == 8'h00 |=> irq.timer_one == 8'h00)
      else $error("masked timer request seen");
   AST_RTI_MASK: assert property (wr && paddr == ADDR_MASK_TWO && !pwdata[BIT_PERIODIC] |=> !irq.periodic)
      else $error("masked periodic request seen");
   AST_RTI_FIRST: assert property (irq.periodic |-> cnt >= RTI_BASE_CYCLES - 1)
      else $error("periodic request too early");
endmodule : tfa_sva
bind tfa_top tfa_sva #(.RTI_BASE_CYCLES(RTI_BASE_CYCLES)) sva_u (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .irq, .capture_strobe, .shared_pin_in, .shared_pin_out_value, .shared_pin_out,
   .shared_pin_oe_n);

/* File: tfa_pin_model.sv */
// External source on the shared accumulator pin.
// Assumes go is a one-cycle request; n pulses follow, two cycles high, two low.
`timescale 1ns/1ns
module tfa_pin_model (
   input wire logic clk,
   input wire logic go,
   input wire logic [3:0] n,
   input wire logic hold,
   output logic pin,
   output logic busy
);
   logic [5:0] ph = '0;
   always @(posedge clk) begin
      if (go) ph <= {n, 2'h0};
      else if (ph != 6'h0) ph <= ph - 6'h1;
   end
   assign pin = hold | ph[1];
   assign busy = ph != 6'h0;
endmodule : tfa_pin_model

/* File: tfa_top_bench.sv */
// Testbench for the timer flag block: APB tasks, event pins and the pin model.
// Assumes a periodic base shortened to 8 cycles.
`timescale 1ns/1ns
module tfa_top_bench;
   import tfa_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   tfa_events_t ev = '0;
   tfa_irq_t irq;
   logic ovf = 0, pv = 0, go = 0, hold = 0, pin, busy, pout, oe_n;
   logic [3:0] np = '0;
   int n_errors = 0, n_tests = 0, t0, t1, m;
   always #5 pclk = ~pclk;
   tfa_top #(.RTI_BASE_CYCLES(8)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hf), .prdata, .pready, .pslverr, .events_in(ev), .timer_overflow(ovf), .shared_pin_in(pin),
      .shared_pin_out_value(pv), .shared_pin_out(pout), .shared_pin_oe_n(oe_n), .irq, .capture_strobe());
   tfa_pin_model pm_u (.clk(pclk), .go, .n(np), .hold, .pin, .busy);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out;
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      check(k < 20, 1);
      r = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [7:0] mk, input logic [7:0] e);
      apb(0, a, 8'h00);
      check(r & {24'hffffff, mk}, {24'h0, e});
   endtask : rd
   // The first edge lets a clear written at the last edge settle before the flag is looked at.
   task automatic wait_rti(output int t);
      int k;
      @(posedge pclk);
      for (k = 0; k < 300 && irq.periodic !== 1'b1; k++) @(posedge pclk);
      check(k < 300, 1);
      t = int'($time / 10);
   endtask : wait_rti
   task automatic pulse(input logic [3:0] n);
      int k;
      np <= n;
      go <= 1;
      @(posedge pclk);
      go <= 0;
      @(posedge pclk);
      for (k = 0; k < 99 && busy !== 1'b0; k++) @(posedge pclk);
      check(k < 99, 1);
      repeat (3) @(posedge pclk);
   endtask : pulse
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      for (m = 0; m < 7; m++) rd(12'(4 * m), m == 4 ? 8'hbf : 8'hff, 8'h00);
      apb(0, 12'h0fc, 8'h00);
      check(r, 32'h0);
      check({31'h0, se}, 32'h1);
      apb(1, ADDR_EDGE_CTRL, 8'hff);
      rd(ADDR_EDGE_CTRL, 8'hff, 8'h3f);
      // Each capture mode sees one rising and one falling edge on channel 0.
      for (m = 0; m < 4; m++) begin
         apb(1, ADDR_EDGE_CTRL, 8'(m));
         apb(1, ADDR_FLAGS_ONE, 8'h07);
         ev.capture_pin[0] <= 1;
         repeat (2) @(posedge pclk);
         rd(ADDR_FLAGS_ONE, 8'h01, {7'h0, m[0]});
         apb(1, ADDR_FLAGS_ONE, 8'h01);
         ev.capture_pin[0] <= 0;
         repeat (2) @(posedge pclk);
         rd(ADDR_FLAGS_ONE, 8'h01, {7'h0, m[1]});
      end
      ev.compare_event <= 5'h1f;
      @(posedge pclk);
      ev.compare_event <= 5'h00;
      @(posedge pclk);
      check(irq.timer_one, 0);
      rd(ADDR_FLAGS_ONE, 8'hf8, 8'hf8);
      apb(1, ADDR_FLAGS_ONE, 8'h00);
      apb(1, ADDR_FLAGS_ONE, 8'h08);
      rd(ADDR_FLAGS_ONE, 8'hf8, 8'hf0);
      apb(1, ADDR_MASK_ONE, 8'h10);
      @(posedge pclk);
      check(irq.timer_one, 8'h10);
      ovf <= 1;
      @(posedge pclk);
      ovf <= 0;
      rd(ADDR_FLAGS_TWO, 8'h8f, 8'h80);
      apb(1, ADDR_MASK_TWO, 8'h40);
      for (m = 0; m < 4; m++) begin
         apb(1, ADDR_ACC_CTRL, 8'(m));
         apb(1, ADDR_FLAGS_TWO, 8'h40);
         wait_rti(t0);
         apb(1, ADDR_FLAGS_TWO, 8'h40);
         wait_rti(t1);
         check(t1 - t0, 8 << m);
      end
      apb(1, ADDR_MASK_TWO, 8'h00);
      apb(1, ADDR_ACC_COUNT, 8'hfe);
      apb(1, ADDR_ACC_CTRL, 8'h50);
      pulse(3);
      rd(ADDR_ACC_COUNT, 8'hff, 8'h01);
      rd(ADDR_FLAGS_TWO, 8'h1f, 8'h10);
      apb(1, ADDR_FLAGS_TWO, 8'h10);
      rd(ADDR_FLAGS_TWO, 8'h10, 8'h00);
      apb(1, ADDR_ACC_CTRL, 8'h10);
      pulse(2);
      rd(ADDR_ACC_COUNT, 8'hff, 8'h01);
      apb(1, ADDR_ACC_COUNT, 8'h00);
      apb(1, ADDR_ACC_CTRL, 8'h70);
      hold <= 1;
      repeat (256) @(posedge pclk);
      hold <= 0;
      repeat (128) @(posedge pclk);
      rd(ADDR_ACC_COUNT, 8'hff, 8'h04);
      pv <= 1;
      apb(1, ADDR_ACC_CTRL, 8'h80);
      @(posedge pclk);
      check({oe_n, pout}, 2'h1);
      apb(1, ADDR_MASK_ONE, 8'h00);
      @(posedge pclk);
      check(irq.timer_one, 8'h00);
      close_out();
   end
endmodule : tfa_top_bench
